/* File: hw/dram_host_defs.svh */
`ifndef DRAM_HOST_DEFS_SVH
`define DRAM_HOST_DEFS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_CMD 4'h8
`define REG_STAT 4'hC

`define CTRL_SEL 0
`define CTRL_EOC_LO 1
`define ADDR_ROW_LO 0
`define ADDR_COL_LO 9
`define ADDR_BANK_LO 18
`define CMD_OP_LO 0
`define CMD_CNT_LO 16
`define STAT_BUSY 0
`define STAT_EOC 1
`define STAT_FLAG 2
`define STAT_ERR 3
`define STAT_ROWS_LO 16

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// device mode codes
// ----------------------------------------
`define MODE_ACCESS 3'h4
`define MODE_REFRESH 3'h0
`define MODE_SET_EOC 3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS 25
`define LEAD_NS 10
`define SEL_NS 50
`define LEAD_CYC ((`LEAD_NS + `CLK_NS - 1) / `CLK_NS)
`define SEL_CYC ((`SEL_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* File: hw/dram_host_pkg.sv */
package dram_host_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADR = 4'h1,
    ST_LAT = 4'h2,
    ST_RAS = 4'h3,
    ST_COL = 4'h4,
    ST_CAS = 4'h5,
    ST_END = 4'h6,
    ST_RF_LEAD = 4'h7,
    ST_RF_LO = 4'h8,
    ST_RF_HI = 4'h9,
    ST_RF_EXIT = 4'hA,
    ST_CLR = 4'hB,
    ST_EOC = 4'hC,
    ST_EOC_LAT = 4'hD
  } state_t;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_RMW = 3'h2,
    OP_REFRESH = 3'h3,
    OP_CLEAR = 3'h4,
    OP_SET_EOC = 3'h5
  } op_t;

endpackage

/* File: hw/flag_sync_if.sv */
`timescale 1ns/100ps
interface flag_sync_if;
  logic level;
  logic fell;
  modport src (output level, output fell);
  modport dst (input level, input fell);
endinterface

/* File: hw/flag_sync.sv */
`timescale 1ns/100ps
module flag_sync (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // raw pin level
  input wire logic pin_i,
  // filtered level and falling event
  flag_sync_if.src sif
);
  logic ff1, ff2, ff3;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ff1 <= 1'b1;
      ff2 <= 1'b1;
      ff3 <= 1'b1;
    end else begin
      ff1 <= pin_i;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // level moves only once the two later stages agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sif.level <= 1'b1;
      sif.fell <= 1'b0;
    end else begin
      sif.fell <= 1'b0;
      if (ff2 == ff3) begin
        sif.level <= ff3;
        sif.fell <= sif.level && !ff3;
      end
    end
  end
endmodule

/* File: hw/dram_host_ctl.sv */
`timescale 1ns/100ps
`include "dram_host_defs.svh"
module dram_host_ctl import dram_host_pkg::*; #(
  parameter int unsigned HOLD_CYC = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // axi4-lite slave
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // device address and control pins
  output logic [8:0] row_addr_in,
  output logic [8:0] col_addr_in,
  output logic bank_sel_lo,
  output logic bank_sel_hi,
  output logic addr_latch_strobe,
  output logic row_strobe_in,
  output logic col_strobe_in,
  output logic row_col_sel,
  output logic host_write_in,
  output logic mode_sel_2,
  output logic mode_sel_1,
  output logic mode_sel_0,
  output logic dev_select_n,
  // refresh flag pin, open drain
  input wire logic refresh_flag_pin_i,
  output logic refresh_flag_pin_o,
  output logic refresh_flag_pin_oe
);
  state_t state;
  op_t op;
  logic [7:0] cnt;
  logic [8:0] remain, rows_done;
  logic aw_got, w_got, wr_fire;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic ctrl_sel;
  logic [1:0] eoc_sel;
  logic [19:0] addr_reg;
  logic [7:0] sel_cnt;
  logic cmd_go, busy, eoc_flag, err_flag;
  logic [2:0] cmd_op;
  logic [8:0] cmd_cnt;
  logic [31:0] next_word;

  flag_sync_if fsi ();
  flag_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin_i(refresh_flag_pin_i),
    .sif(fsi)
  );

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  assign awready = !aw_got && !bvalid;
  assign wready = !w_got && !bvalid;
  assign wr_fire = aw_got && w_got && !bvalid;
  assign busy = (state != ST_IDLE) || cmd_go;
  assign refresh_flag_pin_o = 1'b0;

  function automatic logic [31:0] merge(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    next_word = merge(32'h0000_0000, w_data, w_strb);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control registers and command issue
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_sel <= 1'b0;
      eoc_sel <= 2'h0;
      addr_reg <= 20'h0_0000;
      cmd_go <= 1'b0;
      cmd_op <= 3'h0;
      cmd_cnt <= 9'h000;
      sel_cnt <= 8'h00;
    end else begin
      cmd_go <= 1'b0;
      if (sel_cnt != 8'h00) begin
        sel_cnt <= sel_cnt - 8'h01;
      end
      if (wr_fire && aw_addr == `REG_CTRL && w_strb[0]) begin
        ctrl_sel <= w_data[`CTRL_SEL];
        eoc_sel <= w_data[`CTRL_EOC_LO +: 2];
        // outputs come back only some time after reselect
        if (w_data[`CTRL_SEL] && !ctrl_sel) begin
          sel_cnt <= 8'(`SEL_CYC);
        end
      end
      if (wr_fire && aw_addr == `REG_ADDR) begin
        addr_reg <= 20'(merge({12'h000, addr_reg}, w_data, w_strb));
      end
      if (wr_fire && aw_addr == `REG_CMD && !busy && sel_cnt == 8'h00) begin
        cmd_go <= 1'b1;
        cmd_op <= next_word[`CMD_OP_LO +: 3];
        cmd_cnt <= next_word[`CMD_CNT_LO +: 9];
      end
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // hardware set wins over a same-cycle software clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eoc_flag <= 1'b0;
      err_flag <= 1'b0;
    end else begin
      if (wr_fire && aw_addr == `REG_STAT) begin
        if (next_word[`STAT_EOC]) eoc_flag <= 1'b0;
        if (next_word[`STAT_ERR]) err_flag <= 1'b0;
      end
      if (fsi.fell && (state == ST_RF_LO || state == ST_RF_HI)) begin
        eoc_flag <= 1'b1;
      end
      if (wr_fire && aw_addr == `REG_CMD && (busy || sel_cnt != 8'h00)) begin
        err_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  assign arready = !rvalid;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      case (araddr)
        `REG_CTRL: rdata <= {29'h0, eoc_sel, ctrl_sel};
        `REG_ADDR: rdata <= {12'h000, addr_reg};
        `REG_CMD: rdata <= {7'h00, cmd_cnt, 13'h0000, cmd_op};
        `REG_STAT: rdata <= {7'h00, rows_done, 12'h000, err_flag,
                             fsi.level, eoc_flag, busy};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // pin sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      op <= OP_READ;
      cnt <= 8'h00;
      remain <= 9'h000;
      rows_done <= 9'h000;
      row_addr_in <= 9'h000;
      col_addr_in <= 9'h000;
      {bank_sel_hi, bank_sel_lo} <= 2'h0;
      addr_latch_strobe <= 1'b0;
      row_strobe_in <= 1'b1;
      col_strobe_in <= 1'b1;
      row_col_sel <= 1'b1;
      host_write_in <= 1'b1;
      {mode_sel_2, mode_sel_1, mode_sel_0} <= `MODE_ACCESS;
      refresh_flag_pin_oe <= 1'b0;
      dev_select_n <= 1'b1;
    end else begin
      dev_select_n <= !ctrl_sel;
      if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      case (state)
        ST_IDLE: begin
          if (cmd_go) begin
            op <= op_t'(cmd_op);
            cnt <= 8'(HOLD_CYC);
            case (cmd_op)
              OP_REFRESH: begin
                remain <= cmd_cnt;
                {mode_sel_2, mode_sel_1, mode_sel_0} <= `MODE_REFRESH;
                cnt <= 8'(`LEAD_CYC);
                state <= ST_RF_LEAD;
              end
              OP_CLEAR: begin
                refresh_flag_pin_oe <= 1'b1;
                rows_done <= 9'h000;
                state <= ST_CLR;
              end
              OP_SET_EOC: begin
                {mode_sel_2, mode_sel_1, mode_sel_0} <= `MODE_SET_EOC;
                {bank_sel_hi, bank_sel_lo} <= eoc_sel;
                addr_latch_strobe <= 1'b1;
                state <= ST_EOC;
              end
              OP_READ, OP_WRITE, OP_RMW: begin
                row_addr_in <= addr_reg[`ADDR_ROW_LO +: 9];
                col_addr_in <= addr_reg[`ADDR_COL_LO +: 9];
                {bank_sel_hi, bank_sel_lo} <= addr_reg[`ADDR_BANK_LO +: 2];
                addr_latch_strobe <= 1'b1;
                state <= ST_ADR;
              end
              default: begin
                state <= ST_IDLE;
              end
            endcase
          end
        end
        ST_ADR: if (cnt == 8'h00) begin
          addr_latch_strobe <= 1'b0;
          cnt <= 8'(HOLD_CYC);
          state <= ST_LAT;
        end
        ST_LAT: if (cnt == 8'h00) begin
          row_strobe_in <= 1'b0;
          cnt <= 8'(HOLD_CYC);
          state <= ST_RAS;
        end
        ST_RAS: if (cnt == 8'h00) begin
          row_col_sel <= 1'b0;
          host_write_in <= (op != OP_WRITE);
          cnt <= 8'(HOLD_CYC);
          state <= ST_COL;
        end
        ST_COL: if (cnt == 8'h00) begin
          col_strobe_in <= 1'b0;
          cnt <= 8'(HOLD_CYC);
          state <= ST_CAS;
        end
        ST_CAS: if (cnt == 8'h00) begin
          if (op == OP_RMW && host_write_in) begin
            host_write_in <= 1'b0;
            cnt <= 8'(HOLD_CYC);
          end else begin
            row_strobe_in <= 1'b1;
            col_strobe_in <= 1'b1;
            row_col_sel <= 1'b1;
            host_write_in <= 1'b1;
            cnt <= 8'(HOLD_CYC);
            state <= ST_END;
          end
        end
        ST_END: if (cnt == 8'h00) begin
          state <= ST_IDLE;
        end
        ST_RF_LEAD: if (cnt == 8'h00) begin
          row_strobe_in <= 1'b0;
          cnt <= 8'(HOLD_CYC);
          state <= ST_RF_LO;
        end
        ST_RF_LO: if (cnt == 8'h00) begin
          row_strobe_in <= 1'b1;
          rows_done <= rows_done + 9'h001;
          cnt <= 8'(HOLD_CYC);
          state <= ST_RF_HI;
        end
        ST_RF_HI: if (cnt == 8'h00) begin
          if (remain == 9'h000) begin
            {mode_sel_2, mode_sel_1, mode_sel_0} <= `MODE_ACCESS;
            state <= ST_RF_EXIT;
          end else begin
            remain <= remain - 9'h001;
            row_strobe_in <= 1'b0;
            cnt <= 8'(HOLD_CYC);
            state <= ST_RF_LO;
          end
        end
        ST_RF_EXIT: begin
          state <= ST_IDLE;
        end
        ST_CLR: if (cnt == 8'h00) begin
          refresh_flag_pin_oe <= 1'b0;
          state <= ST_IDLE;
        end
        ST_EOC: if (cnt == 8'h00) begin
          addr_latch_strobe <= 1'b0;
          cnt <= 8'(HOLD_CYC);
          state <= ST_EOC_LAT;
        end
        ST_EOC_LAT: if (cnt == 8'h00) begin
          {mode_sel_2, mode_sel_1, mode_sel_0} <= `MODE_ACCESS;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  addr_stable_a: assert property (
    $fell(addr_latch_strobe) && mode_sel_2 && !mode_sel_0 |->
      $stable(row_addr_in) && $stable(col_addr_in) ##1
      $stable(row_addr_in) && $stable(col_addr_in))
    else $error("address changed at latch strobe fall");
  read_write_a: assert property (
    $fell(col_strobe_in) |-> host_write_in == (op != OP_WRITE))
    else $error("write level wrong when column strobe fell");
  rmw_late_a: assert property (
    $fell(col_strobe_in) && op == OP_RMW |->
      host_write_in [*3] ##1 !host_write_in)
    else $error("late write not issued after column strobe");
  refresh_lead_a: assert property (
    $fell(row_strobe_in) && !mode_sel_2 |-> !$past(mode_sel_2))
    else $error("row strobe fell without refresh mode lead");
  burst_hold_a: assert property (
    $rose(mode_sel_2) && !mode_sel_1 |-> row_strobe_in && col_strobe_in)
    else $error("refresh mode left with row strobe low");
  burst_cas_a: assert property (
    state == ST_RF_LO |-> !mode_sel_2 && col_strobe_in)
    else $error("column strobe active during refresh burst");
  clear_pull_a: assert property (
    cmd_go && cmd_op == OP_CLEAR |=>
      refresh_flag_pin_oe [*3] ##1 !refresh_flag_pin_oe)
    else $error("flag pin pull low has wrong length");

  write_cov: cover property ($fell(col_strobe_in) && op == OP_WRITE);
  rmw_cov: cover property ($fell(host_write_in) && op == OP_RMW);
  burst_cov: cover property (
    $rose(row_strobe_in) && !mode_sel_2 && remain != 9'h000);
  eoc_cov: cover property ($rose(eoc_flag));
endmodule

/* File: test/dram_dev_model.sv */
`timescale 1ns/100ps
`include "dram_host_defs.svh"
module dram_dev_model (
  // address and bank pins from the host
  input wire logic [8:0] row_addr_in,
  input wire logic [8:0] col_addr_in,
  input wire logic bank_sel_lo,
  input wire logic bank_sel_hi,
  // strobes, select and mode
  input wire logic addr_latch_strobe,
  input wire logic row_strobe_in,
  input wire logic col_strobe_in,
  input wire logic row_col_sel,
  input wire logic host_write_in,
  input wire logic mode_sel_2,
  input wire logic mode_sel_1,
  input wire logic mode_sel_0,
  input wire logic dev_select_n,
  // flag pin: level made by outside drivers, own pull-down
  input wire logic ext_flag_n,
  output logic flag_pull,
  // dram side
  output logic [8:0] mux_addr_out,
  output logic [3:0] ras_n,
  output logic cas_n,
  output logic we_n
);
  logic [8:0] row_lat, col_lat, cnt, limit, ras_q;
  logic [1:0] bank_lat;
  logic [13:0] cas_rec;
  logic [5:0] rf_pins;
  logic refr, drive, act, rf_done, late_we, any_ras;
  int lead_errs = 0;
  realtime t_m2 = 0;

  // ----------------------------------------
  // address latches and refresh counter
  // ----------------------------------------
  // power-up clear
  initial begin
    cnt = 9'h000;
    limit = 9'h07F;
    rf_done = 1'b0;
    drive = 1'b0;
  end
  always @*
    if (addr_latch_strobe) begin
      row_lat = row_addr_in;
      col_lat = col_addr_in;
      bank_lat = {bank_sel_hi, bank_sel_lo};
    end
  assign refr = {mode_sel_2, mode_sel_1, mode_sel_0} == `MODE_REFRESH;
  always @(negedge addr_latch_strobe)
    if ({mode_sel_2, mode_sel_1, mode_sel_0} == `MODE_SET_EOC)
      limit = bank_lat[1] ? 9'h1FF : bank_lat[0] ? 9'h0FF : 9'h07F;
  always @(posedge row_strobe_in or posedge mode_sel_2 or negedge ext_flag_n)
    if (!ext_flag_n) begin
      cnt = 9'h000;
      rf_done = 1'b0;
    end else if (rf_done) begin
      cnt = cnt + 9'h001;
      rf_done = 1'b0;
    end
  always @(negedge mode_sel_2) t_m2 = $realtime;
  always @(negedge row_strobe_in)
    if (refr) begin
      rf_done = 1'b1;
      if ($realtime - t_m2 < `LEAD_NS) lead_errs++;
      #1 rf_pins = {cas_n, ras_n, mux_addr_out === cnt};
    end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // outputs return 50 ns after reselect
  always @(dev_select_n)
    if (dev_select_n) drive = 1'b0;
    else drive <= #(`SEL_NS) 1'b1;
  // refresh drives outputs while row strobe is low; weak high shown as plain high
  assign act = drive || (refr && !row_strobe_in);
  assign mux_addr_out = !act ? 9'hZZZ : refr ? cnt :
                        row_col_sel ? row_lat : col_lat;
  // row strobes, cas held off in refresh
  assign ras_n = !act ? 4'hF : refr ? {4{row_strobe_in}} :
                 ~({4{!row_strobe_in}} & (4'h1 << bank_lat));
  assign cas_n = !act || refr || row_col_sel || col_strobe_in;
  assign we_n = !act || host_write_in;
  assign flag_pull = refr && !row_strobe_in && cnt == limit;

  // what the dram saw, for the bench
  assign any_ras = &ras_n;
  always @(negedge any_ras) ras_q = mux_addr_out;
  always @(negedge cas_n) begin
    cas_rec = {we_n, ras_n, mux_addr_out};
    late_we = 1'b0;
  end
  always @(negedge we_n) if (!cas_n) late_we = 1'b1;
endmodule

/* File: test/dram_addr_mux_refresh_ctl_tb_top.sv */
`timescale 1ns/100ps
`include "dram_host_defs.svh"
module dram_addr_mux_refresh_ctl_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, bk;
  logic [8:0] row_addr_in, col_addr_in, rw, cl, base, mux_addr_out;
  logic bank_sel_lo, bank_sel_hi, addr_latch_strobe, row_strobe_in;
  logic col_strobe_in, row_col_sel, host_write_in, dev_select_n;
  logic mode_sel_2, mode_sel_1, mode_sel_0, cas_n, we_n;
  logic flag_o, flag_oe, flag_pull, ext_flag_n, flag_wire;
  logic [3:0] ras_n;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  integer seed = 32'h269AF6A0;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0] r;
  } note_t;
  note_t notes[$];
  note_t nt;

  // open-drain pin with pull-up
  assign ext_flag_n = !(flag_oe && !flag_o);
  assign flag_wire = ext_flag_n && !flag_pull;
  always #12.5 clk = ~clk;

  dram_host_ctl dut_u (
    .clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .row_addr_in, .col_addr_in,
    .bank_sel_lo, .bank_sel_hi, .addr_latch_strobe, .row_strobe_in,
    .col_strobe_in, .row_col_sel, .host_write_in, .mode_sel_2,
    .mode_sel_1, .mode_sel_0, .dev_select_n,
    .refresh_flag_pin_i(flag_wire), .refresh_flag_pin_o(flag_o),
    .refresh_flag_pin_oe(flag_oe)
  );
  dram_dev_model dev_u (
    .row_addr_in, .col_addr_in, .bank_sel_lo, .bank_sel_hi,
    .addr_latch_strobe, .row_strobe_in, .col_strobe_in, .row_col_sel,
    .host_write_in, .mode_sel_2, .mode_sel_1, .mode_sel_0, .dev_select_n,
    .ext_flag_n, .flag_pull, .mux_addr_out, .ras_n, .cas_n, .we_n
  );

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic a_p;
    logic w_p;
    a_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (a_p || w_p) begin
      @(posedge clk);
      if (a_p && awready) begin
        a_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    // bready stays high: a back-to-back call would otherwise drive it twice
    while (!bvalid) @(posedge clk);
    cmp_resp(bresp, r);
  endtask

  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    got = rdata;
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] e, input logic [1:0] r);
    notes.push_back('{e & m, m, r});
    rd(a);
  endtask

  // polls status with no note queued, so the watcher ignores it
  task automatic wait_idle;
    got = 32'h1;
    // a hang is caught by the cycle ceiling, which counts a mismatch
    while (got[`STAT_BUSY] !== 1'b0) rd(`REG_STAT);
  endtask

  task automatic refresh(input int n);
    wr(`REG_CMD, {7'h0, 9'(n - 1), 16'h0003}, `RESP_OKAY);
    wait_idle;
  endtask

  // watcher: oldest note against each read answer that arrives while a note is queued
  always @(posedge clk)
    if (rvalid && rready && notes.size() > 0) begin
      nt = notes.pop_front();
      cmp_word(rdata & nt.m, nt.d);
      cmp_resp(rresp, nt.r);
    end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      give_verdict;
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    cmp_word(32'(dev_u.cnt), 32'h0);
    cmp_word(32'(dev_u.limit), 32'h7F);
    chk_rd(`REG_STAT, 32'h0000000B, 32'h0, `RESP_OKAY);
    chk_rd(4'h2, 32'hFFFFFFFF, 32'h0, `RESP_SLVERR);
    wr(4'h6, 32'h1, `RESP_SLVERR);
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    repeat (4) @(posedge clk);
    cmp_word(32'(dev_select_n), 32'h0);
    for (int op = 0; op < 3; op++) begin
      {rw, cl, bk} = 20'($random(seed));
      wr(`REG_ADDR, {12'h0, bk, cl, rw}, `RESP_OKAY);
      wr(`REG_CMD, 32'(op), `RESP_OKAY);
      wait_idle;
      cmp_word(32'(dev_u.ras_q), 32'(rw));
      cmp_word(32'(dev_u.cas_rec), {18'h0, op != 1, ~(4'h1 << bk), cl});
      cmp_word(32'(dev_u.late_we), 32'(op == 2));
    end
    refresh(5);
    cmp_word(32'(dev_u.cnt), 32'h5);
    cmp_word(32'(dev_u.rf_pins), 32'h21);
    chk_rd(`REG_STAT, 32'h01FF0000, 32'h00050000, `RESP_OKAY);
    wr(`REG_CMD, 32'h4, `RESP_OKAY);
    wait_idle;
    cmp_word(32'(dev_u.cnt), 32'h0);
    base = 9'h000;
    for (int e = 0; e < 3; e++) begin
      wr(`REG_CTRL, 32'(1 + 2 * e), `RESP_OKAY);
      wr(`REG_CMD, 32'h5, `RESP_OKAY);
      wait_idle;
      cmp_word(32'(dev_u.limit), (32'h80 << e) - 1);
      refresh((128 << e) - base - 1);
      chk_rd(`REG_STAT, 32'h2, 32'h0, `RESP_OKAY);
      refresh(1);
      chk_rd(`REG_STAT, 32'h2, 32'h2, `RESP_OKAY);
      wr(`REG_STAT, 32'h2, `RESP_OKAY);
      base = 9'(128 << e);
    end
    cmp_word(32'(dev_u.cnt), 32'h0);
    // a clear sent while busy must be refused
    wr(`REG_CMD, {7'h0, 9'h00F, 16'h0003}, `RESP_OKAY);
    wr(`REG_CMD, 32'h4, `RESP_OKAY);
    wait_idle;
    cmp_word(32'(dev_u.cnt), 32'h10);
    chk_rd(`REG_STAT, 32'h8, 32'h8, `RESP_OKAY);
    wr(`REG_STAT, 32'h8, `RESP_OKAY);
    chk_rd(`REG_STAT, 32'h8, 32'h0, `RESP_OKAY);
    cmp_word(32'(dev_u.lead_errs), 32'h0);
    wr(`REG_CTRL, 32'h0, `RESP_OKAY);
    repeat (3) @(posedge clk);
    cmp_word(32'(dev_select_n), 32'h1);
    give_verdict;
  end
endmodule
